// *** include/dctc_consts.svh ***
/*
 * Constants of the channel trigger control block: register offsets,
 * field positions, reset values and descriptor word offsets.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef DCTC_CONSTS_SVH
`define DCTC_CONSTS_SVH
`define DCTC_REG_CTRL 9'h100
`define DCTC_REG_CTRL2 9'h104
`define DCTC_REG_STATE 9'h108
`define DCTC_REG_DBASE 9'h10c
`define DCTC_REG_WBASE 9'h110
`define DCTC_REG_CHNUM 9'h114
`define DCTC_REGION_BIT 8
`define DCTC_EN_BIT 0
`define DCTC_SWTRIG_BIT 1
`define DCTC_SRC_MSB 4
`define DCTC_SRC_LSB 0
`define DCTC_ACT_MSB 9
`define DCTC_ACT_LSB 8
`define DCTC_ACT_BLOCK 2'h0
`define DCTC_ACT_BEAT 2'h2
`define DCTC_ACT_TXN 2'h3
`define DCTC_KIND_SW 2'h0
`define DCTC_KIND_PERIPH 2'h1
`define DCTC_KIND_EVENT 2'h2
`define DCTC_CTRL2_RESET 32'h0000_0000
`define DCTC_PTR_RESET 32'h0000_0000
`define DCTC_CH_SHIFT 4
`define DCTC_WORD_CTRL 2'h0
`define DCTC_WORD_SRC 2'h1
`define DCTC_WORD_DST 2'h2
`define DCTC_WORD_NEXT 2'h3
`define DCTC_NTRIG 8
`define DCTC_MEM_AW 6
`endif

// *** include/dctc_pkg.sv ***
/*
 * Types of the channel trigger control block.
 * Assumes dctc_consts.svh is on the include path.
 */
`default_nettype none
package dctc_pkg;
	typedef enum logic [2:0] {
		DCTC_OFF,
		DCTC_FETCH,
		DCTC_WAIT,
		DCTC_ARB,
		DCTC_BEAT,
		DCTC_WB
	} dctc_state_e;
	typedef logic [31:0] dctc_word_t;
endpackage : dctc_pkg
`default_nettype wire

// *** verilog/dctc_trig_sync.sv ***
/*
 * Two-flop synchronisers and rising edge detectors for trigger pins.
 * Assumes the pins are asynchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module dctc_trig_sync (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [15:0] pin_in,
	output logic [15:0] rise_out
);
	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					rise_out[i] <= 1'b0;
				end else begin
					s1_reg <= pin_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					rise_out[i] <= s2_reg & ~s3_reg;
				end
			end
		end
	endgenerate
endmodule : dctc_trig_sync
`default_nettype wire

// *** verilog/dctc_desc_mem.sv ***
/*
 * Descriptor memory, 64 words, byte enables, registered read data.
 * Assumes one writer and one reader per cycle, chosen by the parent.
 */
`timescale 1ns/1ps
`default_nettype none
module dctc_desc_mem (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic we_in,
	input wire logic [3:0] be_in,
	input wire logic [5:0] waddr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [5:0] raddr_in,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [0:63];
	// A single process owns the array, so no word has two drivers.
	always_ff @(posedge clk_in) begin
		for (int b = 0; b < 4; b = b + 1) begin
			if (we_in && be_in[b]) begin
				mem[waddr_in][8*b +: 8] <= wdata_in[8*b +: 8];
			end
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 32'h0;
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule : dctc_desc_mem
`default_nettype wire

// *** verilog/dctc_top.sv ***
/*
 * One transfer channel: trigger selection, trigger actions, pending,
 * descriptor fetch and write-back, automatic disable, Avalon-MM slave.
 * Assumes an arbiter answering arb_req_out with grant_in and a beat
 * datapath answering beat_valid_out with beat_done_in, both on clk_in.
 */
// How it works
// - A transfer starts only after a request and an arbitration grant.
// - Trigger comes from software, a peripheral or an event, per select.
// - Action 0x0 whole block (default), 0x2 one beat, 0x3 transaction.
// - Single descriptor: enable cleared once the block completes.
// - Linked chain: enable cleared after the last descriptor runs.
// - Descriptors left: stay enabled, wait for next trigger except with action 0x3.
// - After re-enable no data moves until a fresh trigger.
// - Trigger during transfer is held pending, pending flag set to 1.
// - First descriptor words sit at base plus channel times 0x10 plus offset; linked ones at the next pointer plus offset.
`timescale 1ns/1ps
`default_nettype none
`include "dctc_consts.svh"
module dctc_top import dctc_pkg::*; (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [8:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [7:0] trig_periph_in,
	input wire logic [7:0] trig_event_in,
	output logic arb_req_out,
	input wire logic grant_in,
	output logic beat_valid_out,
	output logic [31:0] beat_src_addr_out,
	output logic [31:0] beat_dst_addr_out,
	input wire logic beat_done_in,
	output logic channel_run_enable_out,
	output logic channel_pending_indicator_out,
	output logic channel_busy_indicator_out
);
	function automatic logic [5:0] word_index(input logic [31:0] ptr,
		input logic [1:0] w);
		word_index = ptr[7:2] + {4'h0, w};
	endfunction : word_index

	function automatic dctc_word_t be_merge(input dctc_word_t old,
		input dctc_word_t nw, input logic [3:0] be);
		integer k;
		be_merge = old;
		for (k = 0; k < 4; k = k + 1) begin
			if (be[k]) begin
				be_merge[8*k +: 8] = nw[8*k +: 8];
			end
		end
	endfunction : be_merge

	dctc_state_e state_reg, state_next;
	logic wait_reg, acc_reg, sw_trig_reg, request_pending_flag_reg, cont_reg;
	logic [2:0] fidx_reg;
	logic [15:0] count_reg, ctrl_hi_reg;
	dctc_word_t ctrl2_reg, dbase_reg, wbase_reg, desc_ptr_reg;
	dctc_word_t src_end_reg, dst_end_reg, next_reg;
	logic [3:0] chnum_reg;
	logic [15:0] rise;
	dctc_word_t mem_rdata, reg_rdata, ch_off, beats_back;
	logic [5:0] mem_raddr, mem_waddr, sw_idx;
	logic req, sel_reg, reg_wr, sw_mem_we, eng_rd, eng_we, mem_we;
	logic trig_now, consume, hw_disable;
	logic [1:0] act, kind;
	logic [2:0] tidx;

	dctc_trig_sync u_sync (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.pin_in({trig_event_in, trig_periph_in}),
		.rise_out(rise)
	);

	// Engine reads outrank software reads, software writes outrank
	// engine writes; the loser waits until the winner is done.
	assign sw_idx = avs_address_in[7:2];
	assign eng_rd = (state_reg == DCTC_FETCH) && !fidx_reg[2];
	assign eng_we = (state_reg == DCTC_WB) && !sw_mem_we;
	assign mem_raddr = eng_rd ? word_index(desc_ptr_reg, fidx_reg[1:0])
		: sw_idx;
	assign mem_waddr = sw_mem_we ? sw_idx
		: word_index(wbase_reg + ch_off, `DCTC_WORD_CTRL);
	assign mem_we = sw_mem_we | eng_we;

	dctc_desc_mem u_mem (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.we_in(mem_we),
		.be_in(sw_mem_we ? avs_byteenable_in : 4'hf),
		.waddr_in(mem_waddr),
		.wdata_in(sw_mem_we ? avs_writedata_in : {ctrl_hi_reg, 16'h0}),
		.raddr_in(mem_raddr),
		.rdata_out(mem_rdata)
	);

	assign req = avs_read_in | avs_write_in;
	assign sel_reg = avs_address_in[`DCTC_REGION_BIT];
	assign reg_wr = !wait_reg && avs_write_in && sel_reg;
	assign sw_mem_we = !wait_reg && avs_write_in && !sel_reg;
	// The channel offset is a shift of the 4-bit channel number, so channels 0 to 15 fit.
	assign ch_off = {28'h0, chnum_reg} << `DCTC_CH_SHIFT;
	assign act = ctrl2_reg[`DCTC_ACT_MSB:`DCTC_ACT_LSB];
	assign kind = ctrl2_reg[`DCTC_SRC_MSB:`DCTC_SRC_MSB - 1];
	assign tidx = ctrl2_reg[`DCTC_SRC_LSB + 2:`DCTC_SRC_LSB];
	// Descriptors hold end addresses; walk back from the final beat.
	assign beats_back = {14'h0, count_reg - 16'h1, 2'b00};

	always_comb begin
		case (kind)
			`DCTC_KIND_SW: trig_now = sw_trig_reg;
			`DCTC_KIND_PERIPH: trig_now = rise[{1'b0, tidx}];
			`DCTC_KIND_EVENT: trig_now = rise[{1'b1, tidx}];
			default: trig_now = 1'b0;
		endcase
	end

	assign consume = (state_reg == DCTC_WAIT) && (trig_now | request_pending_flag_reg);

	always_comb begin
		state_next = state_reg;
		hw_disable = 1'b0;
		case (state_reg)
			DCTC_OFF: begin
				if (channel_run_enable_out) begin
					state_next = DCTC_FETCH;
				end
			end
			DCTC_FETCH: begin
				if (fidx_reg == 3'h4) begin
					if (count_reg == 16'h0) begin
						state_next = DCTC_WB;
					end else if (cont_reg) begin
						state_next = DCTC_ARB;
					end else begin
						state_next = DCTC_WAIT;
					end
				end
			end
			DCTC_WAIT: begin
				if (consume) begin
					state_next = DCTC_ARB;
				end
			end
			DCTC_ARB: begin
				if (grant_in) begin
					state_next = DCTC_BEAT;
				end
			end
			DCTC_BEAT: begin
				if (beat_done_in) begin
					if (count_reg == 16'h1) begin
						state_next = DCTC_WB;
					end else if (act == `DCTC_ACT_BEAT) begin
						state_next = DCTC_WAIT;
					end else begin
						state_next = DCTC_ARB;
					end
				end
			end
			DCTC_WB: begin
				if (!sw_mem_we) begin
					if (next_reg == 32'h0) begin
						state_next = DCTC_OFF;
						hw_disable = 1'b1;
					end else begin
						state_next = DCTC_FETCH;
					end
				end
			end
			default: state_next = DCTC_OFF;
		endcase
		// Disabling mid-beat abandons it; the datapath must tolerate that.
		if (!channel_run_enable_out) begin
			state_next = DCTC_OFF;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= DCTC_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fidx_reg <= 3'h0;
			desc_ptr_reg <= `DCTC_PTR_RESET;
		end else if (state_reg == DCTC_OFF) begin
			fidx_reg <= 3'h0;
			desc_ptr_reg <= dbase_reg + ch_off;
		end else if (state_reg == DCTC_FETCH) begin
			if (fidx_reg != 3'h4) begin
				fidx_reg <= fidx_reg + 3'h1;
			end
		end else if (state_reg == DCTC_WB) begin
			fidx_reg <= 3'h0;
			desc_ptr_reg <= next_reg;
		end
	end

	// Read data trails the read address by one cycle.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_reg <= 16'h0;
			ctrl_hi_reg <= 16'h0;
			src_end_reg <= 32'h0;
			dst_end_reg <= 32'h0;
			next_reg <= 32'h0;
		end else if (state_reg == DCTC_FETCH) begin
			case (fidx_reg)
				3'h1: begin
					count_reg <= mem_rdata[15:0];
					ctrl_hi_reg <= mem_rdata[31:16];
				end
				3'h2: src_end_reg <= mem_rdata;
				3'h3: dst_end_reg <= mem_rdata;
				3'h4: next_reg <= mem_rdata;
				default: next_reg <= next_reg;
			endcase
		end else if (state_reg == DCTC_BEAT && beat_done_in) begin
			count_reg <= count_reg - 16'h1;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			beat_src_addr_out <= 32'h0;
			beat_dst_addr_out <= 32'h0;
		end else if (state_reg == DCTC_ARB && grant_in) begin
			beat_src_addr_out <= src_end_reg - beats_back;
			beat_dst_addr_out <= dst_end_reg - beats_back;
		end
	end

	// A trigger in the very cycle the pending one is taken refills it.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			request_pending_flag_reg <= 1'b0;
		end else if (state_reg == DCTC_OFF) begin
			request_pending_flag_reg <= 1'b0;
		end else if (consume) begin
			request_pending_flag_reg <= request_pending_flag_reg & trig_now;
		end else if (trig_now) begin
			request_pending_flag_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cont_reg <= 1'b0;
		end else if (state_reg == DCTC_OFF) begin
			cont_reg <= 1'b0;
		end else if (consume) begin
			cont_reg <= (act == `DCTC_ACT_TXN);
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			arb_req_out <= 1'b0;
			beat_valid_out <= 1'b0;
			channel_busy_indicator_out <= 1'b0;
			channel_pending_indicator_out <= 1'b0;
		end else begin
			arb_req_out <= (state_next == DCTC_ARB);
			beat_valid_out <= (state_next == DCTC_BEAT);
			channel_busy_indicator_out <= (state_next == DCTC_ARB) ||
				(state_next == DCTC_BEAT) || (state_next == DCTC_WB) ||
				(state_next == DCTC_FETCH && cont_reg);
			channel_pending_indicator_out <= (state_next != DCTC_OFF) &&
				(state_reg != DCTC_OFF) &&
				(consume ? (request_pending_flag_reg & trig_now) : (request_pending_flag_reg | trig_now));
		end
	end

	// Software wins over the automatic disable in the same cycle.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			channel_run_enable_out <= 1'b0;
			sw_trig_reg <= 1'b0;
		end else begin
			sw_trig_reg <= reg_wr && avs_address_in == `DCTC_REG_CTRL &&
				avs_byteenable_in[0] && avs_writedata_in[`DCTC_SWTRIG_BIT];
			if (reg_wr && avs_address_in == `DCTC_REG_CTRL &&
				avs_byteenable_in[0]) begin
				channel_run_enable_out <= avs_writedata_in[`DCTC_EN_BIT];
			end else if (hw_disable) begin
				channel_run_enable_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl2_reg <= `DCTC_CTRL2_RESET;
			dbase_reg <= `DCTC_PTR_RESET;
			wbase_reg <= `DCTC_PTR_RESET;
			chnum_reg <= 4'h0;
		end else if (reg_wr) begin
			case (avs_address_in)
				`DCTC_REG_CTRL2: ctrl2_reg <=
					be_merge(ctrl2_reg, avs_writedata_in, avs_byteenable_in);
				`DCTC_REG_DBASE: dbase_reg <=
					be_merge(dbase_reg, avs_writedata_in, avs_byteenable_in);
				`DCTC_REG_WBASE: wbase_reg <=
					be_merge(wbase_reg, avs_writedata_in, avs_byteenable_in);
				`DCTC_REG_CHNUM: begin
					if (avs_byteenable_in[0]) begin
						chnum_reg <= avs_writedata_in[3:0];
					end
				end
				default: chnum_reg <= chnum_reg;
			endcase
		end
	end

	always_comb begin
		case (avs_address_in)
			`DCTC_REG_CTRL: reg_rdata = {31'h0, channel_run_enable_out};
			`DCTC_REG_CTRL2: reg_rdata = ctrl2_reg &
				32'h0000_031f;
			`DCTC_REG_STATE: reg_rdata = {29'h0, channel_run_enable_out,
				channel_busy_indicator_out, channel_pending_indicator_out};
			`DCTC_REG_DBASE: reg_rdata = dbase_reg;
			`DCTC_REG_WBASE: reg_rdata = wbase_reg;
			`DCTC_REG_CHNUM: reg_rdata = {28'h0, chnum_reg};
			default: reg_rdata = 32'h0;
		endcase
	end

	// Waitrequest idles high and drops for exactly one cycle per access.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			avs_waitrequest_out <= 1'b1;
			acc_reg <= 1'b0;
			avs_readdata_out <= 32'h0;
		end else if (!avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b1;
		end else if (acc_reg) begin
			avs_readdata_out <= mem_rdata;
			avs_waitrequest_out <= 1'b0;
			acc_reg <= 1'b0;
		end else if (req) begin
			if (avs_write_in) begin
				avs_waitrequest_out <= 1'b0;
			end else if (sel_reg) begin
				avs_readdata_out <= reg_rdata;
				avs_waitrequest_out <= 1'b0;
			end else if (!eng_rd) begin
				acc_reg <= 1'b1;
			end
		end
	end

	assign wait_reg = avs_waitrequest_out;
endmodule : dctc_top
`default_nettype wire

// *** verification/dctc_far_model.sv ***
/*
 * Far-side model: the arbiter and the beat datapath facing dctc_top.
 * Assumes the same clock and reset as the channel; slow_in delays
 * both the grant and the beat completion by sixteen cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module dctc_far_model (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic slow_in,
	input wire logic arb_req_in,
	input wire logic beat_valid_in,
	output logic grant_out,
	output logic beat_done_out
);
	logic [4:0] wait_reg;
	// Grant and done are one-cycle pulses, so a held request never gets two in a row.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wait_reg <= 5'h00;
			grant_out <= 1'b0;
			beat_done_out <= 1'b0;
		end else begin
			wait_reg <= 5'h00;
			grant_out <= 1'b0;
			beat_done_out <= 1'b0;
			if ((arb_req_in && !grant_out) ||
				(beat_valid_in && !beat_done_out)) begin
				if (wait_reg >= (slow_in ? 5'h10 : 5'h00)) begin
					grant_out <= arb_req_in;
					beat_done_out <= beat_valid_in;
				end else begin
					wait_reg <= wait_reg + 5'h01;
				end
			end
		end
	end
endmodule : dctc_far_model
`default_nettype wire

// *** verification/dctc_top_asserts.sv ***
/*
 * Port-level checker for dctc_top, bound into every instance.
 * Assumes a single clock domain with active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module dctc_top_chk (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic arb_req_out,
	input wire logic grant_in,
	input wire logic beat_valid_out,
	input wire logic beat_done_in,
	input wire logic channel_run_enable_out,
	input wire logic channel_pending_indicator_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_grant;
		arb_req_out && grant_in;
	endsequence
	sequence s_beat_end;
		beat_valid_out && beat_done_in;
	endsequence
	property p_grant_first;
		$rose(beat_valid_out) |-> $past(arb_req_out) && $past(grant_in);
	endproperty
	a_grant_first: assert property (p_grant_first) else $error("no grant");
	property p_grant_beat;
		s_grant |=> beat_valid_out || !channel_run_enable_out;
	endproperty
	a_grant_beat: assert property (p_grant_beat) else $error("grant lost");
	property p_req_hold;
		arb_req_out && !grant_in |=> arb_req_out || !channel_run_enable_out;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	property p_beat_end;
		s_beat_end |=> !beat_valid_out;
	endproperty
	a_beat_end: assert property (p_beat_end) else $error("beat overran");
	property p_fresh_trig;
		$rose(channel_run_enable_out) |-> !beat_valid_out [*6];
	endproperty
	a_fresh_trig: assert property (p_fresh_trig) else $error("early beat");
	property p_off_quiet;
		!channel_run_enable_out && !$past(channel_run_enable_out)
			|-> !arb_req_out && !beat_valid_out;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("moved when off");
	property p_request_pending_flag_start;
		$fell(channel_pending_indicator_out)
			|-> arb_req_out || $past(arb_req_out) || !channel_run_enable_out;
	endproperty
	a_request_pending_flag_start: assert property (p_request_pending_flag_start) else $error("request_pending_flag fell");
	property p_request_pending_flag_en;
		channel_pending_indicator_out |-> $past(channel_run_enable_out, 2);
	endproperty
	a_request_pending_flag_en: assert property (p_request_pending_flag_en) else $error("request_pending_flag when off");
endmodule : dctc_top_chk
bind dctc_top dctc_top_chk u_dctc_top_chk (.clk_in, .nrst_in, .arb_req_out,
	.grant_in, .beat_valid_out, .beat_done_in, .channel_run_enable_out,
	.channel_pending_indicator_out);
`default_nettype wire

// *** verification/dctc_top_tb.sv ***
/*
 * Self-checking bench for dctc_top with the far-side model.
 * Assumes the package, constants and model are compiled beforehand.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dctc_consts.svh"
module dctc_top_tb import dctc_pkg::*;;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic slow = 1'b0;
	logic [8:0] avs_address_in = 9'h000;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	dctc_word_t avs_writedata_in = 32'h0;
	logic [7:0] trig_periph_in = 8'h00;
	logic [7:0] trig_event_in = 8'h00;
	logic [31:0] avs_readdata_out, beat_src_addr_out, beat_dst_addr_out;
	logic avs_waitrequest_out, arb_req_out, grant_in, beat_valid_out;
	logic beat_done_in, channel_run_enable_out;
	logic channel_pending_indicator_out, channel_busy_indicator_out;
	int miscompares = 0;
	int checks = 0;
	dctc_word_t q;
	logic [31:0] srcq[$], dstq[$];
	dctc_top u_dctc_top (.clk_in, .nrst_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
		.avs_readdata_out, .avs_waitrequest_out, .trig_periph_in,
		.trig_event_in, .arb_req_out, .grant_in, .beat_valid_out,
		.beat_src_addr_out, .beat_dst_addr_out, .beat_done_in,
		.channel_run_enable_out, .channel_pending_indicator_out,
		.channel_busy_indicator_out);
	dctc_far_model u_dctc_far_model (.clk_in, .nrst_in, .slow_in(slow),
		.arb_req_in(arb_req_out), .beat_valid_in(beat_valid_out),
		.grant_out(grant_in), .beat_done_out(beat_done_in));
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		if (beat_valid_out && beat_done_in) begin
			srcq.push_back(beat_src_addr_out);
			dstq.push_back(beat_dst_addr_out);
		end
	end
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_val
	// The request stands until waitrequest is sampled low at a rising
	// edge; read data is taken at that same edge, then released.
	task automatic bus(input logic wr, input logic [8:0] a, input dctc_word_t d);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 40);
		q = avs_readdata_out;
		check_val(32'(n < 40), 32'h1);
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask : bus
	task automatic desc(input logic [8:0] a, input dctc_word_t c, s, d, nx);
		bus(1'b1, a, c);
		bus(1'b1, a + 9'h004, s);
		bus(1'b1, a + 9'h008, d);
		bus(1'b1, a + 9'h00c, nx);
	endtask : desc
	// Pins pass a synchroniser, so each level is held four cycles.
	task automatic pulse(input logic ev, input int i);
		if (ev)
			trig_event_in[i] <= 1'b1;
		else
			trig_periph_in[i] <= 1'b1;
		repeat (4) @(posedge clk_in);
		trig_event_in <= 8'h00;
		trig_periph_in <= 8'h00;
		repeat (4) @(posedge clk_in);
	endtask : pulse
	task automatic wait_beats(input int n);
		for (int k = 0; k < 200 && srcq.size() < n; k++)
			@(posedge clk_in);
		check_val(32'(srcq.size()), 32'(n));
	endtask : wait_beats
	task automatic wait_off();
		for (int k = 0; k < 100 && channel_run_enable_out; k++)
			@(posedge clk_in);
		check_val(32'(channel_run_enable_out), 32'h0);
	endtask : wait_off
	task automatic start(input dctc_word_t ctrl2);
		srcq.delete();
		dstq.delete();
		bus(1'b1, `DCTC_REG_CTRL2, ctrl2);
		bus(1'b1, `DCTC_REG_CTRL, 32'h1);
		repeat (10) @(posedge clk_in);
	endtask : start
	task automatic t_regs();
		bus(1'b0, `DCTC_REG_CTRL2, 32'h0);
		check_val(q, `DCTC_CTRL2_RESET);
		bus(1'b0, `DCTC_REG_DBASE, 32'h0);
		check_val(q, `DCTC_PTR_RESET);
		bus(1'b1, 9'h11c, 32'hffff_ffff);
		bus(1'b0, 9'h11c, 32'h0);
		check_val(q, 32'h0);
		bus(1'b1, `DCTC_REG_WBASE, 32'h80);
		bus(1'b1, `DCTC_REG_CHNUM, 32'h1);
		bus(1'b0, `DCTC_REG_WBASE, 32'h0);
		check_val(q, 32'h80);
		$display("registers test done");
	endtask : t_regs
	task automatic t_block();
		desc(9'h010, 32'h2, 32'h2000_0104, 32'h3000_0204, 32'h0);
		start(32'h0);
		check_val(32'(srcq.size()), 32'h0);
		bus(1'b1, `DCTC_REG_CTRL, 32'h3);
		wait_beats(2);
		check_val(srcq[0], 32'h2000_0100);
		check_val(dstq[1], 32'h3000_0204);
		wait_off();
		bus(1'b0, 9'h090, 32'h0);
		check_val(q & 32'hffff, 32'h0);
		$display("software block test done");
	endtask : t_block
	task automatic t_beat();
		desc(9'h010, 32'h3, 32'h2000_0108, 32'h3000_0208, 32'h0);
		slow <= 1'b1;
		start(32'h20b);
		pulse(1'b0, 3);
		pulse(1'b0, 3);
		bus(1'b0, `DCTC_REG_STATE, 32'h0);
		check_val(32'(q[0]), 32'h1);
		check_val(32'(q[1]), 32'h1);
		pulse(1'b0, 3);
		wait_beats(2);
		repeat (60) @(posedge clk_in);
		check_val(32'(srcq.size()), 32'h2);
		check_val(32'(channel_pending_indicator_out), 32'h0);
		check_val(32'(channel_busy_indicator_out), 32'h0);
		check_val(32'(channel_run_enable_out), 32'h1);
		pulse(1'b0, 3);
		wait_beats(3);
		check_val(srcq[2], 32'h2000_0108);
		wait_off();
		slow <= 1'b0;
		$display("beat pending test done");
	endtask : t_beat
	task automatic t_chain(input dctc_word_t ctrl2);
		desc(9'h010, 32'h1, 32'h2000_0110, 32'h3000_0210, 32'h40);
		desc(9'h040, 32'h2, 32'h2000_0148, 32'h3000_0248, 32'h0);
		start(ctrl2);
		pulse(1'b1, 5);
		if (ctrl2[9:8] == `DCTC_ACT_BLOCK) begin
			wait_beats(1);
			repeat (40) @(posedge clk_in);
			check_val(32'(srcq.size()), 32'h1);
			check_val(32'(channel_run_enable_out), 32'h1);
			pulse(1'b1, 5);
		end
		wait_beats(3);
		check_val(srcq[2], 32'h2000_0148);
		check_val(dstq[1], 32'h3000_0244);
		wait_off();
		$display("linked chain test done");
	endtask : t_chain
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	initial begin
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		t_regs();
		t_block();
		t_beat();
		t_chain(32'h15);
		t_chain(32'h315);
		complete_run();
	end
	// The tests need some hundreds of cycles; this leaves ample margin.
	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		complete_run();
	end
endmodule : dctc_top_tb
`default_nettype wire
